// ---- logic/wdt_pkg.sv ----
package wdt_pkg;
    // Control register field positions.
    localparam int CTL_W          = 8;
    localparam int BIT_CE         = 4;
    localparam int BIT_EN         = 3;
    localparam int SEL_W          = 3;
    localparam int SEL_LSB        = 0;
    localparam logic [2:0] SEL_RST = 3'h0;
    // Timeout counts per period select code.
    localparam int BASE_CYCLES    = 16384;
    localparam int MAX_CYCLES     = 2097152;
    localparam int CNT_W          = 22;
    // Change window length in system clocks.
    localparam int WIN_CYCLES     = 4;
    localparam logic [2:0] WIN_LOAD = 3'h4;
    localparam int SYNC_W         = 2;
    typedef enum logic [1:0] {LVL0, LVL1, LVL2} wdt_level_t;
endpackage : wdt_pkg

// ---- logic/wdt_cfg_if.sv ----
`timescale 1ns/10ps
interface wdt_cfg_if;
    logic       tick;
    logic       run;
    logic       restart;
    logic [2:0] sel;
    logic       expire;
    modport ctl (output run, output restart, output sel, output tick, input expire);
    modport cnt (input run, input restart, input sel, input tick, output expire);
endinterface : wdt_cfg_if

// ---- logic/wdt_counter.sv ----
`timescale 1ns/10ps
module wdt_counter
    import wdt_pkg::*;
(
    // Clock and reset.
    input  wire logic clock,
    input  wire logic rst_b,
    // Control from the main module.
    wdt_cfg_if.cnt    cfg
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] limit;
    logic             expire_q;
    logic             hit;

    assign limit = (CNT_W'(BASE_CYCLES) << cfg.sel) - CNT_W'(1); // [RULE1]
    assign hit   = cfg.tick && (cnt_q >= limit);
    assign cfg.expire = expire_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (!cfg.run || cfg.restart || hit) begin
            cnt_q <= '0; // [RULE14]
        end else if (cfg.tick) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            expire_q <= 1'b0;
        end else begin
            expire_q <= cfg.run && !cfg.restart && hit; // [RULE15]
        end
    end

    chk_counter_clear: assert property (@(posedge clock) disable iff (!rst_b) // [RULE14]
        !cfg.run |=> cnt_q == '0) else $error("counter not cleared while disabled");
    chk_restart_clear: assert property (@(posedge clock) disable iff (!rst_b) // [RULE14]
        cfg.restart |=> cnt_q == '0) else $error("counter not cleared by restart");
    chk_expire_single: assert property (@(posedge clock) disable iff (!rst_b) // [RULE15]
        expire_q |=> !expire_q) else $error("expire longer than one cycle");
endmodule : wdt_counter

// ---- logic/wdt_top.sv ----
`timescale 1ns/10ps
// Functional notes
// RULE1: While enabled the timeout is 16384 oscillator cycles doubled for each select code step.
// RULE2: Level 0 starts disabled and a plain write of enable one turns it on.
// RULE3: Level 0 takes a new period select on any write.
// RULE4: Level 0 disabling needs change-enable and enable set together, then enable cleared.
// RULE5: Level 1 starts disabled and a plain write of enable one turns it on.
// RULE6: Level 1 rejects period change or disable unless made through the timed sequence.
// RULE7: Software opens the level 1 sequence by writing change-enable and enable both one.
// RULE8: In level 1 the second write within four clocks applies enable and period.
// RULE9: Level 2 is always enabled and enable always reads one.
// RULE10: Software opens the level 2 sequence by writing change-enable and enable both one.
// RULE11: In level 2 the second write within four clocks applies the period only.
// RULE12: Fuses pick level 1 when unprogrammed, 2 with always-on, 0 with only compat.
// RULE13: Hardware clears change-enable four clocks after it is written one.
// RULE14: The counter restarts on the restart instruction, while disabled, and on reset.
// RULE15: An expired period gives a reset pulse of one system clock.
// RULE16: A protected change outside the window leaves enable and period unchanged.
module wdt_top
    import wdt_pkg::*;
(
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              rst_b,
    // Watchdog oscillator, unsynchronised.
    input  wire logic              dog_osc,
    // Fuses, programmed is high.
    input  wire logic              always_on_fuse,
    input  wire logic              compat_mode_fuse,
    // Control register port.
    input  wire logic              ctl_wr,
    input  wire logic [CTL_W-1:0]  ctl_wdata,
    input  wire logic              dog_restart_instr,
    output logic      [CTL_W-1:0]  dog_control_reg,
    // Reset request.
    output logic                   dog_reset
);
    wdt_cfg_if cfg ();

    logic [SYNC_W-1:0] osc_sync_q;
    logic              osc_last_q;
    logic [1:0]        fuse_s1_q;
    logic [1:0]        fuse_s2_q;
    logic [1:0]        fuse_vld_q;
    wdt_level_t        level_q;
    logic              lvl_ok_q;
    logic              en_q;
    logic              en_d;
    logic [2:0]        sel_q;
    logic [2:0]        sel_d;
    logic [2:0]        win_q;
    logic [2:0]        win_d;
    logic              ce_q;
    logic              ce_d;
    logic              reset_q;
    logic              w_ce;
    logic              w_en;
    logic [2:0]        w_sel;
    logic              open_wr;
    logic              in_win;
    logic              en_eff;
    wdt_level_t        level_d;

    assign w_ce    = ctl_wdata[BIT_CE];
    assign w_en    = ctl_wdata[BIT_EN];
    assign w_sel   = ctl_wdata[SEL_LSB +: SEL_W];
    assign open_wr = ctl_wr && w_ce && w_en; // [RULE7] [RULE10]
    assign in_win  = ce_q && (win_q != 3'h0);

    assign level_d = fuse_s2_q[1] ? LVL2 : (fuse_s2_q[0] ? LVL0 : LVL1); // [RULE12]
    assign en_eff  = (level_q == LVL2) || en_q; // [RULE9]

    // Next enable: setting is always free, clearing needs an open window.
    assign en_d = !ctl_wr ? en_q :
                  w_ce ? (en_q || w_en) :
                  w_en ? 1'b1 :                              // [RULE2] [RULE5]
                  (in_win ? 1'b0 : en_q);                    // [RULE4] [RULE6] [RULE8] [RULE16]

    assign sel_d = !ctl_wr ? sel_q :
                   (level_q == LVL0) ? w_sel :               // [RULE3]
                   (!w_ce && in_win) ? w_sel : sel_q;        // [RULE6] [RULE8] [RULE11] [RULE16]

    // Change-enable self clears when the window count runs out.
    // Only change-enable and enable written together open it; any other write inside closes it.
    assign win_d = open_wr ? WIN_LOAD :
                   (ctl_wr && in_win) ? 3'h0 :
                   (win_q != 3'h0) ? win_q - 3'h1 : 3'h0;    // [RULE13]
    assign ce_d  = open_wr ? 1'b1 : (win_d != 3'h0);

    // One tick per rising edge of the synchronised oscillator.
    assign cfg.tick    = osc_sync_q[1] && !osc_last_q;
    assign cfg.run     = lvl_ok_q && en_eff;
    assign cfg.restart = dog_restart_instr; // [RULE14]
    assign cfg.sel     = sel_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            osc_sync_q <= '0;
            osc_last_q <= 1'b0;
            fuse_s1_q  <= 2'h0;
            fuse_s2_q  <= 2'h0;
        end else begin
            osc_sync_q <= {osc_sync_q[0], dog_osc};
            osc_last_q <= osc_sync_q[1];
            fuse_s1_q  <= {always_on_fuse, compat_mode_fuse};
            fuse_s2_q  <= fuse_s1_q;
        end
    end

    // The second fuse stage holds valid data two edges after release.
    // The level is frozen on the third edge so that a half-settled fuse never picks it.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fuse_vld_q <= 2'h0;
            level_q    <= LVL1;
            lvl_ok_q   <= 1'b0;
        end else if (!lvl_ok_q) begin
            fuse_vld_q <= {fuse_vld_q[0], 1'b1};
            if (fuse_vld_q[1]) begin
                level_q  <= level_d; // [RULE12]
                lvl_ok_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            en_q  <= 1'b0;
            sel_q <= SEL_RST;
            win_q <= 3'h0;
            ce_q  <= 1'b0;
        end else if (lvl_ok_q) begin
            en_q  <= en_d;
            sel_q <= sel_d;
            win_q <= win_d;
            ce_q  <= ce_d;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reset_q         <= 1'b0;
            dog_control_reg <= '0;
        end else begin
            reset_q         <= cfg.expire; // [RULE15]
            dog_control_reg <= {3'h0, ce_q, en_eff, sel_q}; // [RULE9]
        end
    end
    assign dog_reset = reset_q;

    wdt_counter u_counter (
        .clock (clock),
        .rst_b (rst_b),
        .cfg   (cfg)
    );

    // Opening write of the timed sequence once the level is latched.
    sequence seq_open;
        lvl_ok_q && open_wr;
    endsequence

    // Four cycles with no register write.
    sequence seq_quiet;
        !ctl_wr [*4];
    endsequence

    // Plain write that lands inside an open window.
    sequence seq_apply;
        lvl_ok_q && ctl_wr && !w_ce && in_win;
    endsequence

    chk_lvl2_enable: assert property (@(posedge clock) disable iff (!rst_b) // [RULE9]
        level_q == LVL2 |-> ##1 dog_control_reg[BIT_EN]) else $error("level 2 enable low");
    chk_ce_autoclear: assert property (@(posedge clock) disable iff (!rst_b) // [RULE13]
        seq_open ##1 seq_quiet |=> !ce_q) else $error("ce not cleared");
    chk_pulse_width: assert property (@(posedge clock) disable iff (!rst_b) // [RULE15]
        $rose(reset_q) |=> !reset_q) else $error("reset pulse longer than one cycle");
    chk_lvl1_guard: assert property (@(posedge clock) disable iff (!rst_b) // [RULE16]
        (lvl_ok_q && level_q != LVL0 && ctl_wr && !w_ce && !in_win) |=> $stable(sel_q))
        else $error("protected select changed");
    chk_plain_enable: assert property (@(posedge clock) disable iff (!rst_b) // [RULE5]
        (lvl_ok_q && ctl_wr && w_en) |=> en_q) else $error("enable write lost");
    chk_disable_guard: assert property (@(posedge clock) disable iff (!rst_b) // [RULE4]
        (lvl_ok_q && en_q && ctl_wr && !w_en && !in_win) |=> en_q) else $error("bad disable");
    chk_lvl0_select: assert property (@(posedge clock) disable iff (!rst_b) // [RULE3]
        (lvl_ok_q && level_q == LVL0 && ctl_wr) |=> sel_q == $past(w_sel))
        else $error("level 0 select not taken");
    chk_window_apply: assert property (@(posedge clock) disable iff (!rst_b) // [RULE8]
        (lvl_ok_q && ctl_wr && !w_ce && in_win) |=> sel_q == $past(w_sel))
        else $error("window write not applied");

    chk_window_open: assert property (@(posedge clock) disable iff (!rst_b) // [RULE13]
        seq_open |=> ce_q && (win_q == WIN_LOAD))
        else $error("window not opened");
    chk_apply_closes: assert property (@(posedge clock) disable iff (!rst_b) // [RULE8]
        seq_apply |=> !ce_q && (win_q == 3'h0))
        else $error("window left open after apply");
    chk_disable_apply: assert property (@(posedge clock) disable iff (!rst_b) // [RULE4]
        (lvl_ok_q && ctl_wr && !w_ce && !w_en && in_win) |=> !en_q)
        else $error("window disable not applied");
    chk_ce_only_shut: assert property (@(posedge clock) disable iff (!rst_b) // [RULE13]
        (lvl_ok_q && ctl_wr && w_ce && !w_en) |=> !ce_q)
        else $error("window opened without enable");
    chk_level_frozen: assert property (@(posedge clock) disable iff (!rst_b) // [RULE12]
        lvl_ok_q |=> $stable(level_q))
        else $error("level changed after latch");
    chk_reset_follow: assert property (@(posedge clock) disable iff (!rst_b) // [RULE15]
        cfg.expire |=> dog_reset)
        else $error("expiry gave no reset pulse");
    chk_sel_idle: assert property (@(posedge clock) disable iff (!rst_b) // [RULE16]
        (lvl_ok_q && !ctl_wr) |=> $stable(sel_q))
        else $error("select changed without write");
    chk_en_idle: assert property (@(posedge clock) disable iff (!rst_b) // [RULE16]
        (lvl_ok_q && !ctl_wr) |=> $stable(en_q))
        else $error("enable changed without write");
endmodule : wdt_top

// ---- testbench/test_wdt_top.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_wdt_top;
    import wdt_pkg::*;
    logic             clock = 1'b0;
    logic             rst_b = 1'b0;
    logic             dog_osc = 1'b0;
    logic             always_on_fuse = 1'b0;
    logic             compat_mode_fuse = 1'b0;
    logic             ctl_wr = 1'b0;
    logic [CTL_W-1:0] ctl_wdata = 8'h00;
    logic             dog_restart_instr = 1'b0;
    logic [CTL_W-1:0] dog_control_reg;
    logic             dog_reset;
    int               mismatches = 0;
    int               total_checks = 0;
    int               n;
    always #2 clock = ~clock;
    // The oscillator ticks once every four system clocks.
    always #8 dog_osc = ~dog_osc;
    wdt_top u_dut (.clock(clock), .rst_b(rst_b), .dog_osc(dog_osc),
        .always_on_fuse(always_on_fuse), .compat_mode_fuse(compat_mode_fuse),
        .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .dog_restart_instr(dog_restart_instr),
        .dog_control_reg(dog_control_reg), .dog_reset(dog_reset));
    task automatic do_reset(input logic ao, input logic cm);
        @(negedge clock);
        rst_b = 1'b0;
        always_on_fuse = ao;
        compat_mode_fuse = cm;
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        repeat (5) @(negedge clock);
    endtask : do_reset
    task automatic wr(input logic [CTL_W-1:0] d);
        @(negedge clock);
        ctl_wr = 1'b1;
        ctl_wdata = d;
        @(negedge clock);
        ctl_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [CTL_W-1:0] e);
        repeat (2) @(negedge clock);
        `CHK(dog_control_reg, e)
    endtask : rd
    task automatic test_level0;
        do_reset(1'b0, 1'b1);
        `CHK(dog_control_reg, 8'h00)
        wr(8'h0D); rd(8'h0D);
        wr(8'h0E); rd(8'h0E);
        wr(8'h06); rd(8'h0E);
        wr(8'h18); wr(8'h00); rd(8'h00);
        $display("test_level0 done");
    endtask : test_level0
    task automatic test_level1;
        do_reset(1'b0, 1'b0);
        `CHK(dog_control_reg, 8'h00)
        wr(8'h08); rd(8'h08);
        wr(8'h0B); rd(8'h08);
        wr(8'h03); rd(8'h08);
        wr(8'h18); wr(8'h03); rd(8'h03);
        wr(8'h18); wr(8'h0C); rd(8'h0C);
        wr(8'h18); rd(8'h1C);
        repeat (4) @(negedge clock);
        `CHK(dog_control_reg, 8'h0C)
        wr(8'h02); rd(8'h0C);
        wr(8'h10); wr(8'h03); rd(8'h0C);
        $display("test_level1 done");
    endtask : test_level1
    task automatic test_level2;
        do_reset(1'b1, 1'b0);
        `CHK(dog_control_reg, 8'h08)
        wr(8'h00); rd(8'h08);
        wr(8'h05); rd(8'h08);
        wr(8'h18); wr(8'h02); rd(8'h0A);
        wr(8'h18); wr(8'h00); rd(8'h08);
        do_reset(1'b1, 1'b1);
        `CHK(dog_control_reg, 8'h08)
        $display("test_level2 done");
    endtask : test_level2
    task automatic test_timeout;
        do_reset(1'b1, 1'b0);
        repeat (100) @(negedge clock);
        dog_restart_instr = 1'b1;
        @(negedge clock);
        dog_restart_instr = 1'b0;
        n = 0;
        while (dog_reset !== 1'b1 && n < 80000) begin
            @(negedge clock);
            n++;
        end
        `CHK(n inside {[BASE_CYCLES*4-8:BASE_CYCLES*4+24]}, 1'b1)
        @(negedge clock);
        `CHK(dog_reset, 1'b0)
        $display("test_timeout done");
    endtask : test_timeout
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    initial begin
        test_level0();
        test_level1();
        test_level2();
        test_timeout();
        end_sim();
    end
    initial begin
        #(90000 * 4);
        mismatches++;
        end_sim();
    end
endmodule : test_wdt_top
